//--- hw/storage_ctrl_cfg.svh
// constants for the storage controller command handler
// Summary of operation
// - sleep command stops the internal oscillator and suspends the core.
// - sleep ends on usb bus activity or a new command byte.
// - in spi mode an active chip select also ends sleep.
// - after the wake delay the core posts a wake-up interrupt.
// - full reset holds the core in reset 35 ms, or 1 ms on parallel.
// - echo test returns the bitwise complement of its one input byte.
// - on parallel the data port reads zero until a command arrives.
// - mode 10h: serial-out carries no interrupt, floats while deselected.
// - mode 90h: serial-out always driven, shows interrupt level while deselected.
// - length query takes 68h, returns four bytes, low byte first.
// - length set takes 68h and four bytes; only the internal variable changes.
// - working-mode byte 00h..07h selects device, sd host or usb host modes.
// - enabled host modes detect attach and detach and interrupt the host.
// - mode 06h emits a start-of-frame pulse every frame period.
// - mode 07h holds usb bus reset until another mode is chosen.
// - mode change completes in 10 us, then the return code 51h is output.
// - status fetch returns the status byte and clears the interrupt request.
// - status bytes are classed by range 10h-1fh, 40h-4fh, 80h-bfh.
// - 14h success, 15h attach, 16h detach.
// - interrupt-generating commands raise the interrupt when done, status is the result.
`ifndef STORAGE_CTRL_CFG_SVH
`define STORAGE_CTRL_CFG_SVH
`define CMD_VERSION 8'h01
`define CMD_SLEEP 8'h03
`define CMD_RESET_ALL 8'h05
`define CMD_ECHO 8'h06
`define CMD_SDO_MODE 8'h0b
`define CMD_GET_LEN 8'h0c
`define CMD_SET_LEN 8'h0d
`define CMD_USB_MODE 8'h15
`define CMD_GET_STATUS 8'h22
`define LEN_KEY 8'h68
`define SDO_KEY 8'h16
`define SDO_MODE_FLOAT 8'h10
`define SDO_MODE_IRQ 8'h90
`define SDO_MODE_RESET 8'h10
`define USB_MODE_RESET 8'h00
`define USB_MODE_HOST_OFF 8'h04
`define USB_MODE_HOST_NOSOF 8'h05
`define USB_MODE_HOST_SOF 8'h06
`define USB_MODE_HOST_BUSRST 8'h07
`define USB_MODE_SD_HOST 8'h03
`define USB_MODE_MAX 8'h07
`define ST_OP_OK 8'h14
`define ST_ATTACH 8'h15
`define ST_DETACH 8'h16
`define ST_WAKE 8'h1e
`define RET_OK 8'h51
`define RET_ABORT 8'h5f
`define VERSION_BYTE 8'h41
`define IF_PARALLEL 2'h0
`define IF_SPI 2'h1
`define CLK_MHZ 100
`define RESET_MS 35
`define RESET_PAR_MS 1
`define MODE_US 10
`define WAKE_US 2000
`define SOF_US 1000
`endif

//--- hw/storage_ctrl_pkg.sv
// types for the storage controller command handler
package storage_ctrl_pkg;
	typedef enum {S_IDLE, S_ARG, S_OUT, S_SLEEP, S_WAKE, S_RESET, S_MODE} cmd_state_t;
	typedef enum logic [1:0] {CLS_OTHER, CLS_OPER, CLS_WARN, CLS_ERROR} status_class_t;
	typedef logic [1:0] link_if_t;
endpackage

//--- hw/delay_if.sv
// start and done handshake between the command handler and its delay timer
`timescale 1ns/1ns
interface delay_if;
	logic start;
	logic [31:0] cycles;
	logic busy;
	logic done;
	modport ctl (output start, output cycles, input busy, input done);
	modport tmr (input start, input cycles, output busy, output done);
endinterface

//--- hw/delay_timer.sv
// one-shot down counter for reset, wake and mode-change delays
`timescale 1ns/1ns
module delay_timer (
	input wire logic sys_clk,
	input wire logic rst_n,
	delay_if.tmr dly
);
	import storage_ctrl_pkg::*;
	logic [31:0] cnt_q;
	logic busy_q;
	logic done_q;

	// a start while busy reloads, so a later request always wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (dly.start) begin
				cnt_q <= (dly.cycles > 32'h1) ? dly.cycles - 32'h1 : 32'h0;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (cnt_q == 32'h0) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 32'h1;
				end
			end
		end
	end

	assign dly.busy = busy_q;
	assign dly.done = done_q;
endmodule // delay_timer

//--- hw/storage_ctrl.sv
// command handler of the storage controller: sleep, reset, echo, serial-out mode, length, usb mode, status
`timescale 1ns/1ns
`include "storage_ctrl_cfg.svh"
module storage_ctrl #(
	parameter int RESET_CYCLES = `RESET_MS * 1000 * `CLK_MHZ,
	parameter int RESET_PAR_CYCLES = `RESET_PAR_MS * 1000 * `CLK_MHZ,
	parameter int WAKE_CYCLES = `WAKE_US * `CLK_MHZ,
	parameter int SOF_CYCLES = `SOF_US * `CLK_MHZ
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire storage_ctrl_pkg::link_if_t link_sel,
	input wire logic cmd_stb,
	input wire logic wr_stb,
	input wire logic [7:0] wr_data,
	input wire logic rd_stb,
	output logic [7:0] rd_data,
	input wire logic spi_select_n,
	input wire logic spi_tx_bit,
	output logic spi_serial_out_o,
	output logic spi_serial_out_oe,
	output logic int_n,
	input wire logic usb_activity,
	input wire logic usb_attached,
	output logic osc_enable,
	output logic core_reset,
	output logic [7:0] usb_mode,
	output logic detect_enable,
	output logic sof_pulse,
	output logic usb_bus_reset,
	output logic [31:0] file_length,
	output logic [7:0] irq_status,
	output storage_ctrl_pkg::status_class_t irq_class,
	output logic busy
);
	import storage_ctrl_pkg::*;

	localparam int MODE_CYCLES = `MODE_US * `CLK_MHZ;

	logic rst_n;
	logic [1:0] rst_sync_q;
	logic [1:0] cs_sync_q;
	logic [1:0] act_sync_q;
	logic [1:0] att_sync_q;
	logic [1:0] if_sync0_q;
	logic [1:0] if_sync_q;
	logic att_prev_q;
	logic spi_mode;
	logic cs_active;
	logic [1:0] cs_idle_q;
	logic sleep_wake;

	cmd_state_t state_q;
	logic [7:0] cmd_q;
	logic [2:0] arg_idx_q;
	logic [31:0] len_shadow_q;
	logic [31:0] out_sh_q;
	logic [1:0] out_left_q;
	logic [7:0] rd_data_q;
	logic [7:0] sdo_mode_q;
	logic [7:0] usb_mode_q;
	logic [7:0] mode_req_q;
	logic [31:0] file_len_q;
	logic done_ev;
	logic status_rd;
	logic soft_clear;
	logic irq_q;
	logic [7:0] status_q;
	logic att_pend_q;
	logic det_pend_q;
	status_class_t class_q;
	logic [31:0] sof_cnt_q;
	logic sof_q;
	logic sdo_q;
	logic sdo_oe_q;
	delay_if dly ();
	delay_timer u_delay (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.dly(dly)
	);

	// reset release through two flops
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// pin synchronisers; only the second stage is read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_sync_q <= 2'b11;
			act_sync_q <= 2'b00;
			att_sync_q <= 2'b00;
			if_sync0_q <= 2'b00;
			if_sync_q <= 2'b00;
			att_prev_q <= 1'b0;
			cs_idle_q <= 2'b00;
		end else begin
			cs_sync_q <= {cs_sync_q[0], spi_select_n};
			act_sync_q <= {act_sync_q[0], usb_activity};
			att_sync_q <= {att_sync_q[0], usb_attached};
			if_sync0_q <= link_sel;
			if_sync_q <= if_sync0_q;
			att_prev_q <= att_sync_q[1];
			cs_idle_q <= {cs_idle_q[0], (state_q == S_SLEEP) && !cs_active}; // sleep command's own select in flight
		end
	end
	assign spi_mode = (if_sync_q == `IF_SPI);
	assign cs_active = ~cs_sync_q[1];
	assign sleep_wake = act_sync_q[1] || cmd_stb || (spi_mode && cs_active && (&cs_idle_q));

	// command sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			cmd_q <= 8'h00;
			arg_idx_q <= 3'h0;
			len_shadow_q <= 32'h0;
			out_sh_q <= 32'h0;
			out_left_q <= 2'h0;
			rd_data_q <= 8'h00;
			sdo_mode_q <= `SDO_MODE_RESET;
			usb_mode_q <= `USB_MODE_RESET;
			mode_req_q <= 8'h00;
			file_len_q <= 32'h0;
		end else begin
			unique case (state_q)
				S_SLEEP: begin
					// a waking command byte is consumed by the wake, not executed
					if (sleep_wake) begin
						state_q <= S_WAKE;
					end
				end
				S_WAKE: begin
					if (dly.done) begin
						state_q <= S_IDLE;
					end
				end
				S_RESET: begin
					if (dly.done) begin
						state_q <= S_IDLE;
						rd_data_q <= 8'h00;
						sdo_mode_q <= `SDO_MODE_RESET;
						usb_mode_q <= `USB_MODE_RESET;
						file_len_q <= 32'h0;
						out_left_q <= 2'h0;
					end
				end
				S_MODE: begin
					if (dly.done) begin
						usb_mode_q <= mode_req_q;
						rd_data_q <= `RET_OK;
						state_q <= S_IDLE;
					end
				end
				default: begin
					if (cmd_stb) begin
						cmd_q <= wr_data;
						arg_idx_q <= 3'h0;
						out_left_q <= 2'h0;
						state_q <= S_ARG;
						unique case (wr_data)
							`CMD_SLEEP: state_q <= S_SLEEP;
							`CMD_RESET_ALL: state_q <= S_RESET;
							`CMD_VERSION: begin
								rd_data_q <= `VERSION_BYTE;
								state_q <= S_IDLE;
							end
							`CMD_GET_STATUS: begin
								rd_data_q <= status_q;
								state_q <= S_IDLE;
							end
							default: ;
						endcase
					end else if (state_q == S_ARG && wr_stb) begin
						arg_idx_q <= arg_idx_q + 3'h1;
						unique case (cmd_q)
							`CMD_ECHO: begin
								rd_data_q <= ~wr_data;
								state_q <= S_IDLE;
							end
							`CMD_SDO_MODE: begin
								if (arg_idx_q == 3'h0) begin
									if (wr_data != `SDO_KEY) begin
										state_q <= S_IDLE;
									end
								end else begin
									if (wr_data == `SDO_MODE_FLOAT || wr_data == `SDO_MODE_IRQ) begin
										sdo_mode_q <= wr_data;
									end
									state_q <= S_IDLE;
								end
							end
							`CMD_GET_LEN: begin
								if (wr_data == `LEN_KEY) begin
									rd_data_q <= file_len_q[7:0];
									out_sh_q <= {8'h00, file_len_q[31:8]};
									out_left_q <= 2'h3;
									state_q <= S_OUT;
								end else begin
									state_q <= S_IDLE;
								end
							end
							`CMD_SET_LEN: begin
								if (arg_idx_q == 3'h0) begin
									if (wr_data != `LEN_KEY) begin
										state_q <= S_IDLE;
									end
								end else begin
									// low byte first; only the variable changes, the medium waits for close
									len_shadow_q <= {wr_data, len_shadow_q[31:8]};
									if (arg_idx_q == 3'h4) begin
										file_len_q <= {wr_data, len_shadow_q[31:8]};
										state_q <= S_IDLE;
									end
								end
							end
							`CMD_USB_MODE: begin
								if (wr_data <= `USB_MODE_MAX) begin
									mode_req_q <= wr_data;
									state_q <= S_MODE;
								end else begin
									rd_data_q <= `RET_ABORT;
									state_q <= S_IDLE;
								end
							end
							default: state_q <= S_IDLE;
						endcase
					end else if (state_q == S_OUT && rd_stb) begin
						if (out_left_q == 2'h0) begin
							state_q <= S_IDLE;
						end else begin
							rd_data_q <= out_sh_q[7:0];
							out_sh_q <= {8'h00, out_sh_q[31:8]};
							out_left_q <= out_left_q - 2'h1;
						end
					end
				end
			endcase
		end
	end

	// timer starts on entry to each delayed state
	always_comb begin
		dly.start = 1'b0;
		dly.cycles = 32'h0;
		if ((state_q == S_IDLE || state_q == S_ARG || state_q == S_OUT) && cmd_stb && wr_data == `CMD_RESET_ALL) begin
			dly.start = 1'b1;
			dly.cycles = (if_sync_q == `IF_PARALLEL) ? RESET_PAR_CYCLES : RESET_CYCLES;
		end else if (state_q == S_SLEEP && sleep_wake) begin
			dly.start = 1'b1;
			dly.cycles = WAKE_CYCLES;
		end else if (state_q == S_ARG && wr_stb && cmd_q == `CMD_USB_MODE && wr_data <= `USB_MODE_MAX) begin
			dly.start = 1'b1;
			dly.cycles = MODE_CYCLES;
		end
	end

	// the wake-up is the only command completion that raises the interrupt
	assign done_ev = (state_q == S_WAKE) && dly.done;
	assign status_rd = (state_q == S_IDLE || state_q == S_ARG || state_q == S_OUT) && cmd_stb &&
		wr_data == `CMD_GET_STATUS;
	assign soft_clear = (state_q == S_RESET) && dly.done;

	// interrupt request and status byte; an attach or detach already pending at the fetch keeps the request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
			status_q <= 8'h00;
			att_pend_q <= 1'b0;
			det_pend_q <= 1'b0;
		end else if (soft_clear) begin
			irq_q <= 1'b0;
			status_q <= 8'h00;
			att_pend_q <= 1'b0;
			det_pend_q <= 1'b0;
		end else begin
			if (done_ev) begin
				irq_q <= 1'b1;
				status_q <= `ST_WAKE;
			end else if (att_pend_q && (!irq_q || status_rd)) begin
				irq_q <= 1'b1;
				status_q <= `ST_ATTACH;
				att_pend_q <= 1'b0;
			end else if (det_pend_q && (!irq_q || status_rd)) begin
				irq_q <= 1'b1;
				status_q <= `ST_DETACH;
				det_pend_q <= 1'b0;
			end else if (status_rd) begin
				irq_q <= 1'b0;
			end
			if (detect_enable && att_sync_q[1] && !att_prev_q) begin
				att_pend_q <= 1'b1;
			end
			if (detect_enable && !att_sync_q[1] && att_prev_q) begin
				det_pend_q <= 1'b1;
			end
		end
	end

	// status class by code range
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			class_q <= CLS_OTHER;
		end else if (status_q[7:4] == 4'h1) begin
			class_q <= CLS_OPER;
		end else if (status_q[7:4] == 4'h4) begin
			class_q <= CLS_WARN;
		end else if (status_q[7:6] == 2'b10) begin
			class_q <= CLS_ERROR;
		end else begin
			class_q <= CLS_OTHER;
		end
	end

	// frame tick only in the sof host mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sof_cnt_q <= 32'h0;
			sof_q <= 1'b0;
		end else if (usb_mode_q != `USB_MODE_HOST_SOF) begin
			sof_cnt_q <= 32'h0;
			sof_q <= 1'b0;
		end else if (sof_cnt_q == SOF_CYCLES - 1) begin
			sof_cnt_q <= 32'h0;
			sof_q <= 1'b1;
		end else begin
			sof_cnt_q <= sof_cnt_q + 32'h1;
			sof_q <= 1'b0;
		end
	end

	// serial-out pin: shift data while selected in spi mode, else per mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdo_q <= 1'b1;
			sdo_oe_q <= 1'b0;
		end else if (spi_mode && cs_active) begin
			sdo_q <= spi_tx_bit;
			sdo_oe_q <= 1'b1;
		end else if (sdo_mode_q == `SDO_MODE_IRQ) begin
			sdo_q <= ~irq_q;
			sdo_oe_q <= 1'b1;
		end else begin
			sdo_q <= 1'b1;
			sdo_oe_q <= 1'b0;
		end
	end

	assign rd_data = rd_data_q;
	assign spi_serial_out_o = sdo_q;
	assign spi_serial_out_oe = sdo_oe_q;
	assign int_n = ~irq_q;
	assign osc_enable = (state_q != S_SLEEP);
	assign core_reset = (state_q == S_RESET);
	assign usb_mode = usb_mode_q;
	assign detect_enable = (usb_mode_q >= `USB_MODE_HOST_NOSOF) && (usb_mode_q <= `USB_MODE_HOST_BUSRST);
	assign sof_pulse = sof_q;
	assign usb_bus_reset = (usb_mode_q == `USB_MODE_HOST_BUSRST);
	assign file_length = file_len_q;
	assign irq_status = status_q;
	assign irq_class = class_q;
	assign busy = (state_q == S_WAKE) || (state_q == S_RESET) || (state_q == S_MODE) || (state_q == S_SLEEP);
endmodule // storage_ctrl

//--- test/storage_ctrl_assertions.sv
// port assertions of the storage controller command handler
`timescale 1ns/1ns
module storage_ctrl_assertions (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic cmd_stb,
	input wire logic wr_stb,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic int_n,
	input wire logic osc_enable,
	input wire logic core_reset,
	input wire logic [7:0] usb_mode,
	input wire logic detect_enable,
	input wire logic sof_pulse,
	input wire logic usb_bus_reset,
	input wire logic [7:0] irq_status,
	input wire storage_ctrl_pkg::status_class_t irq_class,
	input wire logic busy
);
	import storage_ctrl_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	function automatic status_class_t cls(input logic [7:0] s);
		if (s >= 8'h10 && s <= 8'h1f) return CLS_OPER;
		if (s >= 8'h40 && s <= 8'h4f) return CLS_WARN;
		if (s >= 8'h80 && s <= 8'hbf) return CLS_ERROR;
		return CLS_OTHER;
	endfunction
	a_echo_invert: assert property ((cmd_stb && wr_data == 8'h06 && !busy) ##1 (wr_stb && !cmd_stb)
		|=> rd_data == ~$past(wr_data)) else $error("echo answer wrong");
	a_bad_mode_abort: assert property ((cmd_stb && wr_data == 8'h15 && !busy) ##1
		(wr_stb && !cmd_stb && wr_data > 8'h07) |=> rd_data == 8'h5f) else $error("bad mode not refused");
	a_sleep_osc_off: assert property (cmd_stb && wr_data == 8'h03 && !busy |=> !osc_enable)
		else $error("oscillator still on");
	a_status_release: assert property (cmd_stb && wr_data == 8'h22 && !busy && !int_n
		|=> int_n || irq_status != $past(irq_status)) else $error("request not cleared");
	a_detect_modes: assert property ($stable(usb_mode)
		|-> detect_enable == (usb_mode inside {8'h05, 8'h06, 8'h07})) else $error("detect enable wrong");
	a_bus_reset_hold: assert property ($stable(usb_mode) |-> usb_bus_reset == (usb_mode == 8'h07))
		else $error("bus reset wrong");
	a_sof_mode_six: assert property (sof_pulse |-> $past(usb_mode) == 8'h06 ##1 !sof_pulse)
		else $error("frame pulse wrong");
	a_reset_busy: assert property ($rose(core_reset) |-> (core_reset && busy)[*8])
		else $error("full reset too short");
	a_class_lag: assert property (1'b1 |=> irq_class == cls($past(irq_status)))
		else $error("status class wrong");
endmodule // storage_ctrl_assertions
bind storage_ctrl storage_ctrl_assertions i_chk (.sys_clk(sys_clk), .nrst(nrst), .cmd_stb(cmd_stb),
	.wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .int_n(int_n), .osc_enable(osc_enable),
	.core_reset(core_reset), .usb_mode(usb_mode), .detect_enable(detect_enable), .sof_pulse(sof_pulse),
	.usb_bus_reset(usb_bus_reset), .irq_status(irq_status), .irq_class(irq_class), .busy(busy));

//--- test/host_model.sv
// host side of the command link: strobes, chip select and serial data
`timescale 1ns/1ns
module host_model (
	input wire logic sys_clk,
	output logic cmd_stb,
	output logic wr_stb,
	output logic [7:0] wr_data,
	output logic rd_stb,
	output logic spi_select_n,
	output logic spi_tx_bit
);
	initial begin
		cmd_stb = 1'b0;
		wr_stb = 1'b0;
		wr_data = 8'h00;
		rd_stb = 1'b0;
		spi_select_n = 1'b1;
		spi_tx_bit = 1'b0;
	end
	always @(negedge sys_clk) spi_tx_bit <= ~spi_tx_bit;
	task automatic send(input logic is_cmd, input logic [7:0] b);
		@(negedge sys_clk);
		cmd_stb <= is_cmd;
		wr_stb <= !is_cmd;
		wr_data <= b;
		rd_stb <= 1'b0;
		spi_select_n <= 1'b0;
	endtask
	// released data flips so a stale byte never looks valid
	task automatic idle();
		@(negedge sys_clk);
		cmd_stb <= 1'b0;
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		wr_data <= ~wr_data;
		spi_select_n <= 1'b1;
	endtask
	task automatic take();
		@(negedge sys_clk);
		cmd_stb <= 1'b0;
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
	endtask
	task automatic select_pulse();
		@(negedge sys_clk);
		spi_select_n <= 1'b0;
		repeat (3) @(negedge sys_clk);
		spi_select_n <= 1'b1;
	endtask
endmodule // host_model

//--- test/storage_ctrl_command_set_tb_top.sv
// testbench of the storage controller command handler
`timescale 1ns/1ns
module storage_ctrl_command_set_tb_top;
	import storage_ctrl_pkg::*;
	logic sys_clk, nrst, usb_activity, usb_attached, cmd_stb, wr_stb, rd_stb, spi_select_n, spi_tx_bit;
	logic spi_serial_out_o, spi_serial_out_oe, int_n, osc_enable, core_reset, detect_enable, sof_pulse;
	logic usb_bus_reset, busy;
	logic [7:0] wr_data, rd_data, usb_mode, irq_status, b;
	logic [31:0] file_length, seed, len;
	logic [7:0] exp_q[$];
	link_if_t link_sel;
	status_class_t irq_class;
	int n_fail, samples_checked, cnt, m;
	host_model i_host (.sys_clk(sys_clk), .cmd_stb(cmd_stb), .wr_stb(wr_stb), .wr_data(wr_data),
		.rd_stb(rd_stb), .spi_select_n(spi_select_n), .spi_tx_bit(spi_tx_bit));
	storage_ctrl #(.RESET_CYCLES(50), .RESET_PAR_CYCLES(20), .WAKE_CYCLES(30), .SOF_CYCLES(40)) i_dut (
		.sys_clk(sys_clk), .nrst(nrst), .link_sel(link_sel), .cmd_stb(cmd_stb), .wr_stb(wr_stb),
		.wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .spi_select_n(spi_select_n),
		.spi_tx_bit(spi_tx_bit), .spi_serial_out_o(spi_serial_out_o), .spi_serial_out_oe(spi_serial_out_oe),
		.int_n(int_n), .usb_activity(usb_activity), .usb_attached(usb_attached), .osc_enable(osc_enable),
		.core_reset(core_reset), .usb_mode(usb_mode), .detect_enable(detect_enable), .sof_pulse(sof_pulse),
		.usb_bus_reset(usb_bus_reset), .file_length(file_length), .irq_status(irq_status),
		.irq_class(irq_class), .busy(busy));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// sel 0 waits for an idle core, sel 1 for a pending request
	task automatic wait_for(input int sel, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			if (sel == 0 ? (busy === 1'b0 && core_reset === 1'b0) : int_n === 1'b0) break;
			@(negedge sys_clk);
		end
		if (i == lim) begin
			chk("timeout", 0, 1);
			final_report();
		end
	endtask
	task automatic fetch(input logic [7:0] exp);
		chk("irq_status", irq_status, exp);
		i_host.send(1, 8'h22);
		i_host.idle();
		chk("status", rd_data, exp);
		chk("int_n", int_n, 1);
		i_host.idle();
		chk("class", irq_class, CLS_OPER);
	endtask
	task automatic set_mode(input logic [7:0] md);
		i_host.send(1, 8'h15);
		i_host.send(0, md);
		i_host.idle();
		@(negedge sys_clk);
		wait_for(0, 1100);
		chk("mode_ret", rd_data, 8'h51);
		chk("mode", usb_mode, md);
		chk("detect", detect_enable, md >= 5 && md <= 7);
		chk("bus_reset", usb_bus_reset, md == 7);
	endtask
	task automatic nap(input int by_select);
		i_host.send(1, 8'h03);
		i_host.idle();
		repeat (5) @(negedge sys_clk);
		chk("asleep", osc_enable, 0);
		if (by_select) i_host.select_pulse();
		else begin
			usb_activity = 1'b1;
			repeat (3) @(negedge sys_clk);
			usb_activity = 1'b0;
		end
		wait_for(1, 200);
		chk("awake", osc_enable, 1);
		fetch(8'h1e);
	endtask
	task automatic check_sdo(input logic oe, input logic lvl);
		repeat (4) @(negedge sys_clk);
		chk("sdo_oe", spi_serial_out_oe, oe);
		if (oe) chk("sdo_lvl", spi_serial_out_o, lvl);
	endtask
	initial begin
		nrst = 1'b0;
		link_sel = 2'h0;
		usb_activity = 1'b0;
		usb_attached = 1'b0;
		seed = 32'h4d67;
		n_fail = 0;
		samples_checked = 0;
		repeat (6) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk("rd_idle", rd_data, 8'h00);
		check_sdo(0, 1);
		for (cnt = 0; cnt < 6; cnt++) begin
			seed = lfsr(seed);
			b = (cnt == 0) ? 8'h57 : seed[7:0];
			i_host.send(1, 8'h06);
			i_host.send(0, b);
			i_host.idle();
			chk("echo", rd_data, 8'hff ^ b);
		end
		seed = lfsr(seed);
		len = seed;
		i_host.send(1, 8'h0d);
		i_host.send(0, 8'h68);
		for (cnt = 0; cnt < 4; cnt++) begin
			i_host.send(0, len[8*cnt+:8]);
			exp_q.push_back(len[8*cnt+:8]);
		end
		i_host.idle();
		chk("length", file_length, len);
		i_host.send(1, 8'h0c);
		i_host.send(0, 8'h68);
		i_host.idle();
		for (cnt = 0; cnt < 4; cnt++) begin
			chk("len_byte", rd_data, exp_q.pop_front());
			i_host.take();
			i_host.idle();
		end
		for (m = 0; m < 8; m++) begin
			set_mode(m[7:0]);
			if (m == 6) begin
				cnt = 0;
				repeat (120) begin
					@(negedge sys_clk);
					cnt += sof_pulse;
				end
				chk("sof_count", cnt, 3);
			end
		end
		i_host.send(1, 8'h15);
		i_host.send(0, 8'h08);
		i_host.idle();
		chk("bad_mode", rd_data, 8'h5f);
		chk("mode_kept", usb_mode, 8'h07);
		set_mode(8'h05);
		usb_attached = 1'b1;
		wait_for(1, 50);
		fetch(8'h15);
		set_mode(8'h07);
		set_mode(8'h06);
		usb_attached = 1'b0;
		wait_for(1, 50);
		fetch(8'h16);
		nap(0);
		i_host.send(1, 8'h05);
		i_host.idle();
		cnt = 0;
		while (core_reset === 1'b1 && cnt < 100) begin
			@(negedge sys_clk);
			cnt++;
		end
		chk("reset_len", cnt >= 18 && cnt <= 22, 1);
		wait_for(0, 100);
		chk("mode_after", usb_mode, 8'h00);
		link_sel = 2'h1;
		i_host.send(1, 8'h0b);
		i_host.send(0, 8'h16);
		i_host.send(0, 8'h90);
		i_host.idle();
		check_sdo(1, 1);
		set_mode(8'h05);
		usb_attached = 1'b1;
		wait_for(1, 50);
		check_sdo(1, 0);
		fetch(8'h15);
		i_host.send(1, 8'h0b);
		i_host.send(0, 8'h16);
		i_host.send(0, 8'h10);
		i_host.idle();
		check_sdo(0, 1);
		nap(1);
		final_report();
	end
endmodule // storage_ctrl_command_set_tb_top
